// File: core/prc_regs.sv
// power rail control register bank top level
`timescale 1ns/1ps
module prc_regs
	import prc_pkg::*;
#(
	parameter int         POWER_CYCLE = prc_pkg::POWER_CYCLE_CYC,
	parameter int         PLT_HOLD    = prc_pkg::PLT_HOLD_CYC,
	// arbitrary neutral type code
	parameter logic [5:0] TYPE_CODE   = 6'h2a
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave port
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// live status levels
	input  wire logic        over_temp,
	input  wire logic        charging,
	input  wire logic        batt_present,
	input  wire logic        batt_detect_done,
	input  wire logic        batt_safe_mode,
	// shutdown and startup cause pulses
	input  wire logic        key_override_evt,
	input  wire logic        cold_off_evt,
	input  wire logic        undervoltage_lockout_evt,
	input  wire logic        batt_insert_evt,
	input  wire logic        chg_insert_evt,
	input  wire logic        key_start_evt,
	// reset requests and platform pins
	input  wire logic        sys_reset_req,
	input  wire logic        global_reset_req,
	input  wire logic        sleep_exit_n,
	input  wire logic        platform_reset_n,
	// rail controls
	output logic      [7:0]  switcher_en,
	output logic      [7:0]  linear_en_a,
	output logic      [7:0]  linear_en_b,
	output logic             rails_off,
	output logic             switcher_e_dual,
	output logic             switcher_cd_merge,
	output logic             use_sleep_volt,
	output logic      [4:0]  digital_linear_a_code,
	output logic      [4:0]  digital_linear_b_code
);
	import prc_pkg::*;

	// bus side signals
	logic [7:0] idx;          // register index of the access
	logic       wr_pulse;     // write data phase
	logic [7:0] wdata;        // write byte
	logic       rd_pulse;     // read data phase
	logic [7:0] rdata;        // read mux result

	// stored state
	logic [7:0] reason_r;     // power up/down reason log
	logic [7:0] scratch_r [12]; // retained scratch bytes
	logic [7:0] live_r [3];   // live rail enable registers
	logic [7:0] shadow_r [3]; // shadow rail enable buffer
	logic [7:0] ctrl_r;       // synchronous on/off control
	logic [7:0] dla_r;        // digital linear a voltage
	logic [7:0] dlb_r;        // digital linear b voltage
	logic [7:0] sw_out_r;     // gated switcher enables
	logic [7:0] la_out_r;     // gated linear a enables
	logic [7:0] lb_out_r;     // gated linear b enables

	// reset and sequencing
	logic       seq_off;      // rails held off
	logic       seq_done;     // power cycle finished
	logic       cold_clr;     // cold domain clear
	logic       sys_clr;      // system domain clear
	logic       cold_req;     // start a power cycle
	logic       glb_cold;     // global reset upgraded

	// write decodes
	logic       wr_reason;    // reason register write
	logic       wr_ctrl;      // control register write
	logic       wr_dla;       // linear a voltage write
	logic       wr_dlb;       // linear b voltage write
	prc_slot_t  wr_slot;      // enable slot addressed

	// map an index to a rail enable slot
	function automatic prc_slot_t rail_slot(input logic [7:0] i);
		case (i)
			IDX_SW_EN: rail_slot = PRC_SLOT_SW;
			IDX_LIN_A: rail_slot = PRC_SLOT_LA;
			IDX_LIN_B: rail_slot = PRC_SLOT_LB;
			default:   rail_slot = PRC_SLOT_NONE;
		endcase
	endfunction

	// writable mask of a rail enable slot
	function automatic logic [7:0] slot_mask(input prc_slot_t s);
		case (s)
			PRC_SLOT_SW: slot_mask = MSK_SW_EN;
			PRC_SLOT_LA: slot_mask = MSK_LIN_A;
			PRC_SLOT_LB: slot_mask = MSK_LIN_B;
			default:     slot_mask = 8'h00;
		endcase
	endfunction

	// bus front end
	prc_ahb_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.idx       (idx),
		.wr_pulse  (wr_pulse),
		.wdata     (wdata),
		.rd_pulse  (rd_pulse),
		.rdata     (rdata)
	);

	// power cycle sequencer
	prc_cold_seq #(
		.OFF_CYC  (POWER_CYCLE),
		.HOLD_CYC (PLT_HOLD)
	) u_seq (
		.hclk             (hclk),
		.hresetn          (hresetn),
		.req              (cold_req),
		.arm              (ctrl_r[CB_PLT_ARM]),
		.sleep_exit_n     (sleep_exit_n),
		.platform_reset_n (platform_reset_n),
		.rails_off        (seq_off),
		.done             (seq_done)
	);

	// write decode
	assign wr_reason = wr_pulse & (idx == IDX_REASON);
	assign wr_ctrl   = wr_pulse & (idx == IDX_CTRL);
	assign wr_dla    = wr_pulse & (idx == IDX_DLA_V);
	assign wr_dlb    = wr_pulse & (idx == IDX_DLB_V);
	assign wr_slot   = wr_pulse ? rail_slot(idx) : PRC_SLOT_NONE;

	// cold reset sources: software request, upgraded global reset
	assign glb_cold = global_reset_req & ctrl_r[CB_GLB_COLD];
	assign cold_req = (wr_ctrl & wdata[CB_COLD_REQ]) | glb_cold;

	// cold reset lands when rails come back; it also clears system state
	assign cold_clr = seq_done;
	assign sys_clr  = cold_clr | sys_reset_req | (global_reset_req & ~ctrl_r[CB_GLB_COLD]);

	// reason log: set wins over write-one-clear, power-on reset only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reason_r <= 8'h00;
		end else begin
			reason_r <= (reason_r & ~(wr_reason ? wdata : 8'h00)) | {
				key_override_evt,
				cold_off_evt,
				undervoltage_lockout_evt,
				seq_done,
				global_reset_req,
				batt_insert_evt,
				chg_insert_evt,
				key_start_evt
			};
		end
	end

	// scratch bytes survive cold and system resets
	genvar g;
	generate
		for (g = 0; g < 12; g++) begin : g_scr
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					scratch_r[g] <= 8'h00;
				else if (wr_pulse && idx == IDX_SCR_LO + 8'(g))
					scratch_r[g] <= wdata;
			end
		end
	endgenerate

	// live and shadow rail enables
	generate
		for (g = 0; g < 3; g++) begin : g_rail
			// live registers: cold reset domain
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					live_r[g] <= (g == 0) ? RST_SW_EN : (g == 1) ? RST_LIN_A : RST_LIN_B;
				end else if (cold_clr) begin
					live_r[g] <= (g == 0) ? RST_SW_EN : (g == 1) ? RST_LIN_A : RST_LIN_B;
				end else if (wr_ctrl && wdata[CB_COMMIT]) begin
					live_r[g] <= shadow_r[g];
				end else if (wr_slot == prc_slot_t'(g) && !ctrl_r[CB_SHADOW]) begin
					live_r[g] <= wdata & slot_mask(prc_slot_t'(g));
				end
			end
			// shadow buffer: loaded from live on entering shadow mode
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					shadow_r[g] <= 8'h00;
				end else if (wr_ctrl && wdata[CB_SHADOW] && !ctrl_r[CB_SHADOW]) begin
					shadow_r[g] <= live_r[g];
				end else if (wr_slot == prc_slot_t'(g) && ctrl_r[CB_SHADOW]) begin
					shadow_r[g] <= wdata & slot_mask(prc_slot_t'(g));
				end
			end
		end
	endgenerate

	// control: bits 6:5 cold domain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r[CB_DUAL_E]   <= RST_CTRL[CB_DUAL_E];
			ctrl_r[CB_MERGE_CD] <= RST_CTRL[CB_MERGE_CD];
		end else if (cold_clr) begin
			ctrl_r[CB_DUAL_E]   <= RST_CTRL[CB_DUAL_E];
			ctrl_r[CB_MERGE_CD] <= RST_CTRL[CB_MERGE_CD];
		end else if (wr_ctrl) begin
			ctrl_r[CB_DUAL_E]   <= wdata[CB_DUAL_E];
			ctrl_r[CB_MERGE_CD] <= wdata[CB_MERGE_CD];
		end
	end

	// control: bit 3 power-on reset only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctrl_r[CB_PLT_ARM] <= RST_CTRL[CB_PLT_ARM];
		else if (wr_ctrl)
			ctrl_r[CB_PLT_ARM] <= wdata[CB_PLT_ARM];
	end

	// control: bits 7, 4 and 2 system domain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r[CB_GLB_COLD] <= RST_CTRL[CB_GLB_COLD];
			ctrl_r[CB_SLEEP_V]  <= RST_CTRL[CB_SLEEP_V];
			ctrl_r[CB_COLD_REQ] <= RST_CTRL[CB_COLD_REQ];
		end else if (sys_clr) begin
			ctrl_r[CB_GLB_COLD] <= RST_CTRL[CB_GLB_COLD];
			ctrl_r[CB_SLEEP_V]  <= RST_CTRL[CB_SLEEP_V];
			ctrl_r[CB_COLD_REQ] <= RST_CTRL[CB_COLD_REQ];
		end else if (wr_ctrl) begin
			ctrl_r[CB_GLB_COLD] <= wdata[CB_GLB_COLD];
			ctrl_r[CB_SLEEP_V]  <= wdata[CB_SLEEP_V];
			ctrl_r[CB_COLD_REQ] <= wdata[CB_COLD_REQ];
		end
	end

	// control: bits 1:0, commit clears both
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r[CB_SHADOW] <= RST_CTRL[CB_SHADOW];
			ctrl_r[CB_COMMIT] <= RST_CTRL[CB_COMMIT];
		end else if (sys_clr) begin
			ctrl_r[CB_SHADOW] <= RST_CTRL[CB_SHADOW];
			ctrl_r[CB_COMMIT] <= RST_CTRL[CB_COMMIT];
		end else if (wr_ctrl) begin
			// a commit self-clears in the same write
			ctrl_r[CB_SHADOW] <= wdata[CB_COMMIT] ? 1'b0 : wdata[CB_SHADOW];
			ctrl_r[CB_COMMIT] <= 1'b0;
		end
	end

	// digital linear a voltage: cold domain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dla_r <= RST_VOLT;
		else if (cold_clr)
			dla_r <= RST_VOLT;
		else if (wr_dla)
			dla_r <= wdata & MSK_VOLT;
	end

	// digital linear b voltage: system domain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dlb_r <= RST_VOLT;
		else if (sys_clr)
			dlb_r <= RST_VOLT;
		else if (wr_dlb)
			dlb_r <= wdata & MSK_VOLT;
	end

	// read mux; reads never alter state
	always_comb begin
		rdata = 8'h00;
		case (idx)
			IDX_STATUS: begin
				rdata = {over_temp, charging, batt_present, batt_detect_done,
					batt_safe_mode, 3'b000};
			end
			IDX_REASON: rdata = reason_r;
			IDX_TYPE:   rdata = {TYPE_CODE[5:4], 2'b00, TYPE_CODE[3:0]};
			IDX_CTRL:   rdata = ctrl_r;
			IDX_DLA_V:  rdata = dla_r;
			IDX_DLB_V:  rdata = dlb_r;
			default: begin
				if (idx >= IDX_SCR_LO && idx <= IDX_SCR_HI)
					rdata = scratch_r[4'(idx - IDX_SCR_LO)];
				else if (rail_slot(idx) != PRC_SLOT_NONE)
					// shadow mode reads the buffer
					rdata = ctrl_r[CB_SHADOW] ? shadow_r[rail_slot(idx)]
						: live_r[rail_slot(idx)];
			end
		endcase
	end

	// rail enables gated off during a power cycle
	// the clear cycle stays gated too, so stale enables never flash on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_out_r  <= 8'h00;
			la_out_r  <= 8'h00;
			lb_out_r  <= 8'h00;
			rails_off <= 1'b0;
		end else begin
			sw_out_r  <= (seq_off | seq_done) ? 8'h00 : live_r[0];
			la_out_r  <= (seq_off | seq_done) ? 8'h00 : live_r[1];
			lb_out_r  <= (seq_off | seq_done) ? 8'h00 : live_r[2];
			rails_off <= seq_off;
		end
	end

	// output wiring from registers
	assign switcher_en           = sw_out_r;
	assign linear_en_a           = la_out_r;
	assign linear_en_b           = lb_out_r;
	assign switcher_e_dual       = ctrl_r[CB_DUAL_E];
	assign switcher_cd_merge     = ctrl_r[CB_MERGE_CD];
	assign use_sleep_volt        = ctrl_r[CB_SLEEP_V];
	assign digital_linear_a_code = dla_r[4:0];
	assign digital_linear_b_code = dlb_r[4:0];
endmodule // prc_regs

// File: core/prc_pkg.sv
// constants and register map of the power rail control register bank
package prc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS  = 8'h01;
	localparam logic [7:0] IDX_REASON  = 8'h02;
	localparam logic [7:0] IDX_TYPE    = 8'h03;
	localparam logic [7:0] IDX_SCR_LO  = 8'h04;
	localparam logic [7:0] IDX_SCR_HI  = 8'h0f;
	localparam logic [7:0] IDX_SW_EN   = 8'h10;
	localparam logic [7:0] IDX_LIN_A   = 8'h12;
	localparam logic [7:0] IDX_LIN_B   = 8'h13;
	localparam logic [7:0] IDX_CTRL    = 8'h14;
	localparam logic [7:0] IDX_DLA_V   = 8'h15;
	localparam logic [7:0] IDX_DLB_V   = 8'h16;
	// reset values
	localparam logic [7:0] RST_SW_EN   = 8'h7b;
	localparam logic [7:0] RST_LIN_A   = 8'h08;
	localparam logic [7:0] RST_LIN_B   = 8'h9c;
	localparam logic [7:0] RST_CTRL    = 8'h48;
	localparam logic [7:0] RST_VOLT    = 8'h16;
	// writable bit masks
	localparam logic [7:0] MSK_SW_EN   = 8'h7b;
	localparam logic [7:0] MSK_LIN_A   = 8'h7f;
	localparam logic [7:0] MSK_LIN_B   = 8'hfc;
	localparam logic [7:0] MSK_VOLT    = 8'h1f;
	// control field positions
	localparam int CB_GLB_COLD  = 7;
	localparam int CB_DUAL_E    = 6;
	localparam int CB_MERGE_CD  = 5;
	localparam int CB_SLEEP_V   = 4;
	localparam int CB_PLT_ARM   = 3;
	localparam int CB_COLD_REQ  = 2;
	localparam int CB_SHADOW    = 1;
	localparam int CB_COMMIT    = 0;
	// reason field positions
	localparam int RB_COLD_RST  = 4;
	localparam int RB_GLB_RST   = 3;
	// timing
	localparam int CLK_KHZ        = 100000;
	localparam int POWER_CYCLE_MS = 64;
	localparam int PLT_HOLD_MS    = 512;
	localparam int POWER_CYCLE_CYC = POWER_CYCLE_MS * CLK_KHZ;
	localparam int PLT_HOLD_CYC    = PLT_HOLD_MS * CLK_KHZ;
	// rail enable register slots
	typedef enum logic [1:0] {PRC_SLOT_SW, PRC_SLOT_LA, PRC_SLOT_LB, PRC_SLOT_NONE} prc_slot_t;
endpackage

// File: core/prc_ahb_slave.sv
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module prc_ahb_slave (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [7:0]  idx,
	output logic             wr_pulse,
	output logic      [7:0]  wdata,
	output logic             rd_pulse,
	input  wire logic [7:0]  rdata
);
	logic [7:0] idx_r;   // captured register index
	logic       wr_r;    // write data phase pending
	logic       rd_r;    // read wait state pending
	logic       take;    // address phase accepted
	assign take = hsel & htrans[1] & hready;
	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_r <= 8'h00;
			wr_r  <= 1'b0;
			rd_r  <= 1'b0;
		end else begin
			if (take)
				idx_r <= haddr[9:2];
			wr_r <= take & hwrite;
			rd_r <= take & ~hwrite;
		end
	end
	// ready and read data; the wait state lets any write land first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
		end else begin
			hreadyout <= ~(take & ~hwrite);
			if (rd_r)
				hrdata <= {24'h00_0000, rdata};
		end
	end
	assign hresp    = 1'b0;
	assign idx      = idx_r;
	assign wr_pulse = wr_r;
	assign wdata    = hwdata[7:0];
	assign rd_pulse = rd_r;
endmodule // prc_ahb_slave

// File: core/prc_cold_seq.sv
// cold reset sequencer with platform reset hold timer
`timescale 1ns/1ps
module prc_cold_seq #(
	parameter int OFF_CYC  = 6400000,
	parameter int HOLD_CYC = 51200000
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic req,
	input  wire logic arm,
	input  wire logic sleep_exit_n,
	input  wire logic platform_reset_n,
	output logic      rails_off,
	output logic      done
);
	typedef enum logic {PRC_IDLE, PRC_OFF} prc_seq_t;
	prc_seq_t         st_r;     // sequence state
	logic [31:0]      off_r;    // power-down counter
	logic [31:0]      hold_r;   // platform reset hold counter
	logic             fire;     // hold time reached
	assign fire = (hold_r == 32'(HOLD_CYC - 1)) & arm & sleep_exit_n & ~platform_reset_n;
	// hold timer runs only while the condition stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hold_r <= 32'h0;
		else if (!(arm & sleep_exit_n & ~platform_reset_n) || st_r == PRC_OFF)
			hold_r <= 32'h0;
		else if (hold_r != 32'(HOLD_CYC - 1))
			hold_r <= hold_r + 32'h1;
	end
	// rails off for the power cycle, then back on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r  <= PRC_IDLE;
			off_r <= 32'h0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st_r)
				PRC_IDLE: begin
					off_r <= 32'h0;
					if (req | fire)
						st_r <= PRC_OFF;
				end
				PRC_OFF: begin
					off_r <= off_r + 32'h1;
					if (off_r == 32'(OFF_CYC - 1)) begin
						st_r <= PRC_IDLE;
						done <= 1'b1;
					end
				end
				default: st_r <= PRC_IDLE;
			endcase
		end
	end
	assign rails_off = (st_r == PRC_OFF);
endmodule // prc_cold_seq

// File: test/prc_host.sv
// ahb-lite master model standing in for host software
`timescale 1ns/1ps
module prc_host (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	// idle bus from time zero
	initial begin
		hsel   = 1'b0;
		haddr  = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'b010;
		hwdata = '0;
	end
	// one single word transfer; stale write data is inverted so it never looks valid
	task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] wd,
		output logic [7:0] rd);
		hsel   <= 1'b1;
		haddr  <= {22'h0, i, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		hwdata <= ~hwdata;
		// hold the address phase until it is taken
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		// hold the data phase until the answer
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata[7:0];
	endtask
endmodule // prc_host

// File: test/prc_regs_assertions.sv
// port checker of the power rail control register bank
`timescale 1ns/1ps
module prc_regs_assertions
	import prc_pkg::*;
#(
	parameter int POWER_CYCLE = 20,
	parameter int PLT_HOLD    = 30
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        sleep_exit_n,
	input wire logic        platform_reset_n,
	input wire logic [7:0]  switcher_en,
	input wire logic [7:0]  linear_en_a,
	input wire logic [7:0]  linear_en_b,
	input wire logic        rails_off,
	input wire logic        switcher_e_dual,
	input wire logic        switcher_cd_merge,
	input wire logic [4:0]  digital_linear_a_code
);
	logic wctl_r; // control write in its data phase
	int   off_r;  // cycles seen with rails off
	int   hold_r; // cycles of platform hold, arm bit assumed set
	// track control writes, off time and hold time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wctl_r <= 1'b0;
			off_r  <= 0;
			hold_r <= 0;
		end else begin
			wctl_r <= hsel && htrans[1] && hready && hwrite && haddr[9:2] == IDX_CTRL;
			off_r  <= rails_off ? off_r + 1 : 0;
			hold_r <= (sleep_exit_n && !platform_reset_n && !rails_off) ? hold_r + 1 : 0;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd; hsel && htrans[1] && hready && !hwrite; endsequence
	sequence s_ans; !hreadyout ##1 hreadyout; endsequence
	property p_rd; s_rd |=> s_ans; endproperty
	a_rd: assert property (p_rd) else $error("read wait wrong");
	property p_hi; hreadyout |-> hrdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_sw; (switcher_en & ~MSK_SW_EN) == 8'h00; endproperty
	a_sw: assert property (p_sw) else $error("switcher reserved bit on");
	property p_la; linear_en_a[7] == 1'b0; endproperty
	a_la: assert property (p_la) else $error("linear a reserved bit on");
	property p_lb; (linear_en_b & ~MSK_LIN_B) == 8'h00; endproperty
	a_lb: assert property (p_lb) else $error("linear b reserved bit on");
	property p_off; rails_off && $past(rails_off) |-> {switcher_en, linear_en_a, linear_en_b} == 24'h0;
	endproperty
	a_off: assert property (p_off) else $error("rail on while off");
	property p_cold; wctl_r && hwdata[CB_COLD_REQ] |-> ##[1:3] rails_off; endproperty
	a_cold: assert property (p_cold) else $error("cold request ignored");
	property p_len; $fell(rails_off) |-> off_r >= POWER_CYCLE - 1 && off_r <= POWER_CYCLE + 1;
	endproperty
	a_len: assert property (p_len) else $error("off time wrong");
	property p_def; $fell(rails_off) |-> ##[0:3] (switcher_e_dual && !switcher_cd_merge
		&& digital_linear_a_code == RST_VOLT[4:0] && switcher_en == RST_SW_EN); endproperty
	a_def: assert property (p_def) else $error("cold defaults missing");
	property p_hold; hold_r >= PLT_HOLD + 3 |-> rails_off; endproperty
	a_hold: assert property (p_hold) else $error("hold did not cycle");
endmodule // prc_regs_assertions
bind prc_regs prc_regs_assertions #(.POWER_CYCLE(POWER_CYCLE), .PLT_HOLD(PLT_HOLD))
	u_prc_regs_assertions (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
	.hreadyout(hreadyout), .sleep_exit_n(sleep_exit_n), .platform_reset_n(platform_reset_n),
	.switcher_en(switcher_en), .linear_en_a(linear_en_a), .linear_en_b(linear_en_b),
	.rails_off(rails_off), .switcher_e_dual(switcher_e_dual),
	.switcher_cd_merge(switcher_cd_merge), .digital_linear_a_code(digital_linear_a_code));

// File: test/power_rail_control_regs_tb.sv
// self-checking bench of the power rail control register bank
`timescale 1ns/1ps
module power_rail_control_regs_tb;
	import prc_pkg::*;
	localparam int PC = 20; // shortened off time
	localparam int PH = 30; // shortened platform hold
	localparam logic [7:0] IX [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0f, 8'h10,
		8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h11};
	localparam logic [7:0] EX [12] = '{8'h00, 8'h00, 8'h8a, 8'h00, 8'h00, 8'h7b,
		8'h08, 8'h9c, 8'h48, 8'h16, 8'h16, 8'h00};
	localparam logic [7:0] RE [12] = '{8'h00, 8'h00, 8'h8a, 8'h00, 8'h00, 8'h7b,
		8'h7f, 8'hfc, 8'h00, 8'h1f, 8'h1f, 8'h00};
	localparam int RB [6] = '{7, 6, 5, 2, 1, 0};
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rails_off;
	logic        dual, merge, slpv, sys_req, glb_req, sleep_exit_n, platform_reset_n;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  sw, la, lb, ev, d;
	logic [4:0]  st, dla, dlb;
	int          fails, n_tests, cyc;
	// design with shortened counts
	prc_regs #(.POWER_CYCLE(PC), .PLT_HOLD(PH)) u_prc_regs (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .over_temp(st[4]), .charging(st[3]), .batt_present(st[2]),
		.batt_detect_done(st[1]), .batt_safe_mode(st[0]), .key_override_evt(ev[7]),
		.cold_off_evt(ev[6]), .undervoltage_lockout_evt(ev[5]), .batt_insert_evt(ev[2]),
		.chg_insert_evt(ev[1]), .key_start_evt(ev[0]), .sys_reset_req(sys_req),
		.global_reset_req(glb_req), .sleep_exit_n(sleep_exit_n),
		.platform_reset_n(platform_reset_n), .switcher_en(sw), .linear_en_a(la),
		.linear_en_b(lb), .rails_off(rails_off), .switcher_e_dual(dual),
		.switcher_cd_merge(merge), .use_sleep_volt(slpv), .digital_linear_a_code(dla),
		.digital_linear_b_code(dlb));
	// host side bus master
	prc_host u_prc_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// compare, count and report
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		u_prc_host.xfer(1'b1, i, v, d);
	endtask
	task automatic rc(input logic [7:0] i, input logic [7:0] e);
		u_prc_host.xfer(1'b0, i, 8'h00, d);
		chk($sformatf("reg %h", i), d, e);
	endtask
	// one-cycle request pulses
	task automatic pul(input logic [7:0] m, input logic g, input logic s);
		ev      <= m;
		glb_req <= g;
		sys_req <= s;
		@(posedge hclk);
		ev      <= 8'h00;
		glb_req <= 1'b0;
		sys_req <= 1'b0;
	endtask
	// bounded wait for a rails_off level
	task automatic wro(input logic v);
		for (int k = 0; k < 100 && rails_off !== v; k++) @(posedge hclk);
		chk("rails_off", rails_off, v);
	endtask
	// defaults, status, reason, reserved bits, shadow, cold, global, hold
	task automatic t_def();
		for (int i = 0; i < 12; i++)
			rc(IX[i], EX[i]);
		chk("enables", {sw, la, lb}, 24'h7b089c);
		chk("ctl out", {dual, merge, slpv, dla, hresp}, {3'b100, 5'h16, 1'b0});
	endtask
	task automatic t_stat();
		for (int i = 0; i < 5; i++) begin
			st <= 5'(1 << i);
			rc(8'h01, 8'(8'h08 << i));
		end
		st <= 5'h00;
	endtask
	task automatic t_rsn();
		for (int i = 0; i < 6; i++) begin
			pul(8'(1 << RB[i]), 1'b0, 1'b0);
			rc(8'h02, 8'(1 << RB[i]));
			rc(8'h02, 8'(1 << RB[i]));
			wr(8'h02, 8'(1 << RB[i]));
			rc(8'h02, 8'h00);
		end
	endtask
	task automatic t_rw();
		for (int i = 0; i < 12; i++) wr(8'(4 + i), 8'(8'h5a + i));
		for (int i = 0; i < 12; i++) rc(8'(4 + i), 8'(8'h5a + i));
		for (int i = 0; i < 12; i++) begin
			if (i == 8 || i < 2 || i == 3 || i == 4) continue;
			wr(IX[i], 8'hff);
			rc(IX[i], RE[i]);
		end
		chk("masked en", {sw, la, lb}, 24'h7b7ffc);
	endtask
	task automatic t_shd();
		wr(8'h14, 8'h4a);
		wr(8'h10, 8'h00);
		rc(8'h10, 8'h00);
		repeat (2) @(posedge hclk);
		chk("live sw", sw, 8'h7b);
		wr(8'h14, 8'h4b);
		repeat (2) @(posedge hclk);
		chk("commit sw", sw, 8'h00);
		rc(8'h14, 8'h48);
	endtask
	task automatic t_cold();
		wr(8'h14, 8'h38);
		repeat (2) @(posedge hclk);
		chk("modes", {dual, merge, slpv}, 3'b011);
		wr(8'h15, 8'h05);
		wr(8'h14, 8'h3c);
		wro(1'b1);
		wro(1'b0);
		repeat (4) @(posedge hclk);
		chk("cold en", {sw, la, lb}, 24'h7b089c);
		chk("cold ctl", {dual, merge, slpv, dla, dlb}, 13'h12d6);
		rc(8'h14, 8'h48);
		rc(8'h02, 8'h10);
		rc(8'h04, 8'h5a);
		wr(8'h02, 8'h10);
	endtask
	task automatic t_glb();
		wr(8'h14, 8'h58);
		pul(8'h00, 1'b0, 1'b1);
		rc(8'h14, 8'h48);
		wr(8'h15, 8'h05);
		wr(8'h16, 8'h04);
		wr(8'h14, 8'h18);
		pul(8'h00, 1'b1, 1'b0);
		repeat (3) @(posedge hclk);
		chk("no cycle", rails_off, 1'b0);
		rc(8'h16, 8'h16);
		rc(8'h15, 8'h05);
		rc(8'h14, 8'h08);
		wr(8'h14, 8'hc8);
		pul(8'h00, 1'b1, 1'b0);
		wro(1'b1);
		wro(1'b0);
		rc(8'h02, 8'h18);
		rc(8'h14, 8'h48);
		wr(8'h02, 8'h18);
	endtask
	task automatic t_hold();
		sleep_exit_n     <= 1'b1;
		platform_reset_n <= 1'b0;
		repeat (PH - 2) @(posedge hclk);
		chk("early", rails_off, 1'b0);
		wro(1'b1);
		platform_reset_n <= 1'b1;
		sleep_exit_n     <= 1'b0;
		wro(1'b0);
		rc(8'h02, 8'h10);
	endtask
	// verdict and end of run
	task automatic summarize();
		if (fails == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// free running clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	// reset, then each scenario in turn
	initial begin
		hresetn          = 1'b0;
		st               = 5'h00;
		ev               = 8'h00;
		sys_req          = 1'b0;
		glb_req          = 1'b0;
		sleep_exit_n     = 1'b0;
		platform_reset_n = 1'b1;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_def();
		t_stat();
		t_rsn();
		t_rw();
		t_shd();
		t_cold();
		t_glb();
		t_hold();
		summarize();
	end
endmodule // power_rail_control_regs_tb
